/* File: rtl/itc_pkg.sv */
// itc_pkg: constants, state enum and carrier structs for the transceiver
// serial control slave. assumes a 40 MHz system clock and a master serial clock.
package itc_pkg;

  // serial framing and timing counts
  localparam int unsigned INIT_EDGES   = 30;   // low-line clocks before first command
  localparam int unsigned TURN_CYCLES  = 4;    // clocks from last command bit to response
  localparam int unsigned BYTE_BITS    = 8;

  // address field values
  localparam logic [2:0] ADDR_INDIV    = 3'h1;
  localparam logic [2:0] ADDR_BCAST    = 3'h7;

  // index codes
  localparam logic [3:0] IDX_CTRL0     = 4'h0;
  localparam logic [3:0] IDX_CTRL1     = 4'h1;
  localparam logic [3:0] IDX_CTRL2     = 4'h2;
  localparam logic [3:0] IDX_RESET     = 4'hD;
  localparam logic [3:0] IDX_EXT       = 4'hF;

  // command byte layout
  localparam int unsigned CMD_ADDR_LSB = 0;
  localparam int unsigned CMD_IDX_LSB  = 3;
  localparam int unsigned CMD_READ_BIT = 7;

  // register reset values and implemented bits
  localparam logic [7:0] CTRL0_RST     = 8'h14;
  localparam logic [7:0] CTRL1_RST     = 8'h00;
  localparam logic [7:0] CTRL2_RST     = 8'h70;
  localparam logic [7:0] CTRL0_MASK    = 8'h17;
  localparam logic [7:0] CTRL1_MASK    = 8'h0F;
  localparam logic [7:0] CTRL2_MASK    = 8'hF0;

  // control register 0 bit positions
  localparam int unsigned C0_PM        = 0;
  localparam int unsigned C0_OEN       = 1;
  localparam int unsigned C0_TLED      = 2;
  localparam int unsigned C0_ACK_PULSE_ENABLE      = 4;

  typedef enum logic [2:0] {
    ITC_INIT, ITC_IDLE, ITC_CMD, ITC_WSTART, ITC_WDATA, ITC_ACK, ITC_TURN, ITC_RESP
  } itc_state_e;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
  } itc_cfg_s;

  localparam itc_cfg_s CFG_RST = '{ctrl0: CTRL0_RST, ctrl1: CTRL1_RST, ctrl2: CTRL2_RST};

  // result of a register write: new contents and whether it may be acknowledged
  typedef struct packed {
    logic     ok;
    itc_cfg_s cfg;
  } itc_wr_s;

  // serial-clock domain state
  typedef struct packed {
    itc_state_e state;
    logic [4:0] cnt;
    logic [7:0] shreg;
    logic [3:0] idx;
    logic       rd;
    logic       hit;
    logic       indiv;
    logic       led_block;
    logic       rx_sel;
    logic       drv;
    logic       drv_oe;
    itc_cfg_s   cfg;
  } itc_link_s;

  // system-clock domain state
  typedef struct packed {
    logic       led;
    logic       pd_o;
    logic       pd_oe;
    logic       pm;
    logic [3:0] ir_mode;
    logic [3:0] tx_pwr;
  } itc_sys_s;

endpackage : itc_pkg

/* File: rtl/itc_sync.sv */
// itc_sync: two-flop level synchroniser, any width, synchronous reset.
// assumes each bit is a slowly changing level, not a multi-bit word in motion.
`timescale 1ns/1ps

module itc_sync #(
  parameter int unsigned W        = 1,
  parameter logic        RST_VAL  = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [1:0][W-1:0] st_q;
  logic [1:0][W-1:0] st_d;

  // first stage feeds only the second
  always_comb begin
    st_d[0] = d;
    st_d[1] = st_q[0];
  end

  // stage registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= {(2*W){RST_VAL}};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q[1];

endmodule : itc_sync

/* File: rtl/itc_serial_ctrl.sv */
// itc_serial_ctrl: slave end of the transceiver serial control interface,
// with LED gating and receiver-line steering. assumes the master makes
// link_clk and stops it when idle; optics sit outside on plain pins.
`timescale 1ns/1ps

// Behaviour
// - master starts every transaction; slave only answers, never initiates.
// - each transaction has a command phase, response phase only for reads.
// - response start bit comes exactly 4 clocks after the last command bit.
// - bytes within a phase follow back to back without idle clocks.
// - every byte goes LSB first behind exactly one start bit.
// - data sampled on rising edge; slave changes its output after rising edge.
// - idle write-data line drives the emitter LED directly.
// - LED blocked from first rising edge of a command through its shifting.
// - LED released on last command clock, for reads when the write line falls; further clocks block it again. here only a new start bit blocks it.
// - during read response photodiode is cut off and read data driven.
// - addressed slave drives read data regardless of output enable; others float. here others keep the photodiode path, driven while output enable is set.
// - with ack enabled, read line pulses low one clock after each write.
// - slave ends a read when it sees the write-data line fall.
// - idle bus and optics: write line low, read line high.
// - three-bit address; answer to individual 001 and broadcast 111.
// - index 0-2 control registers, D reset, F read extended, rest unused.
// - ack only if ack enable, receiver enable and individual address.
// - written configuration takes effect only after the command completes.
module itc_serial_ctrl
  import itc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       link_clk,
  input  wire logic       tx_write_data_line,
  input  wire logic       pd_rx_in,
  output logic            rx_read_data_line_o,
  output logic            rx_read_data_line_oe,
  output logic            led_drive,
  output logic            power_mode,
  output logic [3:0]      ir_mode,
  output logic [3:0]      tx_power_level
);

  // ---------------------------------------------------------------- helpers

  // address field decode for this slave
  function automatic logic addr_hit(input logic [2:0] a);
    return (a == ADDR_INDIV) || (a == ADDR_BCAST);
  endfunction : addr_hit

  // register write with field masking and mode-value check
  function automatic itc_wr_s cfg_write(input itc_cfg_s c, input logic [3:0] idx,
                                        input logic [7:0] data);
    itc_wr_s r;
    r.ok  = 1'b1;
    r.cfg = c;
    case (idx)
      IDX_CTRL0: r.cfg.ctrl0 = data & CTRL0_MASK;
      IDX_CTRL1: begin
        if (data == 8'h01 || data == 8'h02 || data == 8'h04 || data == 8'h08) begin
          r.cfg.ctrl1 = data & CTRL1_MASK;
        end else begin
          r.cfg.ctrl1 = CTRL1_RST;  // bad mode value clears and is not acknowledged
          r.ok        = 1'b0;
        end
      end
      IDX_CTRL2: r.cfg.ctrl2 = data & CTRL2_MASK;
      default:   r.ok = 1'b0;
    endcase
    return r;
  endfunction : cfg_write

  // read-back value for an index; unused and extended codes answer zero
  function automatic logic [7:0] cfg_read(input itc_cfg_s c, input logic [3:0] idx);
    case (idx)
      IDX_CTRL0: return c.ctrl0 & CTRL0_MASK;
      IDX_CTRL1: return c.ctrl1 & CTRL1_MASK;
      IDX_CTRL2: return c.ctrl2 & CTRL2_MASK;
      default:   return 8'h00;
    endcase
  endfunction : cfg_read

  // ------------------------------------------------------ serial clock side

  localparam itc_link_s LINK_RST = '{state: ITC_INIT, cfg: CFG_RST, default: '0};
  localparam logic [4:0] INIT_LAST = 5'(INIT_EDGES - 1);
  localparam logic [4:0] TURN_LAST = 5'(TURN_CYCLES - 1);
  localparam logic [4:0] BYTE_LAST = 5'(BYTE_BITS - 1);
  localparam logic [4:0] BYTE_DONE = 5'(BYTE_BITS);

  itc_link_s  l_q;
  itc_link_s  l_d;
  logic       link_rst;
  logic [7:0] cmd_byte;
  logic [7:0] shift_in;
  itc_wr_s    wr;
  logic       ack_ok;
  logic       tx_line;

  // write-data line is launched by the master on the falling edge, so it is
  // already in this domain when sampled on the rising edge
  assign tx_line = tx_write_data_line;

  // system reset carried into the serial domain
  itc_sync #(.W(1), .RST_VAL(1'b1)) u_link_rst (
    .clk (link_clk),
    .rst (1'b0),
    .d   (sys_rst),
    .q   (link_rst)
  );

  // incoming bit enters at the top so the first bit ends in bit 0
  assign shift_in = {tx_line, l_q.shreg[7:1]};
  assign cmd_byte = shift_in;
  assign wr       = cfg_write(l_q.cfg, l_q.idx, shift_in);
  // ack uses the settings in force during the command
  assign ack_ok   = l_q.cfg.ctrl0[C0_ACK_PULSE_ENABLE] & l_q.cfg.ctrl0[C0_OEN];

  // serial protocol sequencer
  always_comb begin
    l_d = l_q;
    case (l_q.state)
      // count low-line clocks; any high restarts the count
      ITC_INIT: begin
        if (tx_line) begin
          l_d.cnt = '0;
        end else if (l_q.cnt == INIT_LAST) begin
          l_d.state = ITC_IDLE;
          l_d.cnt   = '0;
        end else begin
          l_d.cnt = l_q.cnt + 5'h01;
        end
      end
      // start bit opens a command; LED is blocked from this edge
      ITC_IDLE: begin
        if (tx_line) begin
          l_d.state     = ITC_CMD;
          l_d.cnt       = '0;
          l_d.led_block = 1'b1;
        end
      end
      // command byte: address then index then direction
      ITC_CMD: begin
        l_d.shreg = shift_in;
        l_d.cnt   = l_q.cnt + 5'h01;
        if (l_q.cnt == BYTE_LAST) begin
          l_d.idx   = cmd_byte[CMD_IDX_LSB +: 4];
          l_d.rd    = cmd_byte[CMD_READ_BIT];
          l_d.hit   = addr_hit(cmd_byte[CMD_ADDR_LSB +: 3]);
          l_d.indiv = cmd_byte[CMD_ADDR_LSB +: 3] == ADDR_INDIV;
          l_d.cnt   = '0;
          if (cmd_byte[CMD_READ_BIT]) begin
            l_d.state  = ITC_TURN;
            l_d.rx_sel = addr_hit(cmd_byte[CMD_ADDR_LSB +: 3]);
          end else if (cmd_byte[CMD_IDX_LSB +: 4] == IDX_RESET) begin
            // single-byte special command ends the command phase here
            l_d.led_block = 1'b0;
            if (addr_hit(cmd_byte[CMD_ADDR_LSB +: 3])) begin
              l_d.cfg = CFG_RST;
            end
            if (ack_ok && cmd_byte[CMD_ADDR_LSB +: 3] == ADDR_INDIV) begin
              l_d.state  = ITC_ACK;
              l_d.rx_sel = 1'b1;
              l_d.drv    = 1'b0;
              l_d.drv_oe = 1'b1;
            end else begin
              l_d.state = ITC_IDLE;
            end
          end else begin
            l_d.state = ITC_WSTART;
          end
        end
      end
      // start bit of the data byte
      ITC_WSTART: begin
        l_d.state = ITC_WDATA;
        l_d.cnt   = '0;
      end
      // data byte; configuration is committed only at its last bit
      ITC_WDATA: begin
        l_d.shreg = shift_in;
        l_d.cnt   = l_q.cnt + 5'h01;
        if (l_q.cnt == BYTE_LAST) begin
          l_d.led_block = 1'b0;
          if (l_q.hit) begin
            l_d.cfg = wr.cfg;
          end
          if (l_q.hit && l_q.indiv && wr.ok && ack_ok) begin
            l_d.state  = ITC_ACK;
            l_d.rx_sel = 1'b1;
            l_d.drv    = 1'b0;
            l_d.drv_oe = 1'b1;
          end else begin
            l_d.state = ITC_IDLE;
          end
        end
      end
      // ack low for one clock, then hand the line back
      ITC_ACK: begin
        l_d.state  = ITC_IDLE;
        l_d.rx_sel = 1'b0;
        l_d.drv    = 1'b1;
        l_d.drv_oe = 1'b0;
      end
      // turnaround; response start bit on the fourth edge
      ITC_TURN: begin
        if (!tx_line) begin
          l_d.state     = ITC_IDLE;
          l_d.rx_sel    = 1'b0;
          l_d.led_block = 1'b0;
        end else if (l_q.cnt == TURN_LAST) begin
          l_d.state  = ITC_RESP;
          l_d.cnt    = '0;
          l_d.shreg  = cfg_read(l_q.cfg, l_q.idx);
          l_d.drv    = 1'b0;
          l_d.drv_oe = l_q.hit;
        end else begin
          l_d.cnt = l_q.cnt + 5'h01;
        end
      end
      // response byte, then float until the master drops the write line
      ITC_RESP: begin
        if (!tx_line) begin
          l_d.state     = ITC_IDLE;
          l_d.rx_sel    = 1'b0;
          l_d.drv       = 1'b1;
          l_d.drv_oe    = 1'b0;
          l_d.led_block = 1'b0;
        end else if (l_q.cnt == BYTE_DONE) begin
          l_d.drv_oe = 1'b0;
          l_d.drv    = 1'b1;
        end else begin
          l_d.drv   = l_q.shreg[0];
          l_d.shreg = {1'b0, l_q.shreg[7:1]};
          l_d.cnt   = l_q.cnt + 5'h01;
        end
      end
      default: l_d = LINK_RST;
    endcase
  end

  // serial-domain state register, updated after each rising edge
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      l_q <= LINK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // ------------------------------------------------------ system clock side

  itc_sys_s   s_q;
  itc_sys_s   s_d;
  logic [1:0] pin_s;
  logic [12:0] cross_s;
  logic       tx_s;
  logic       pd_s;
  logic       blk_s;
  logic       oen_s;
  logic       ack_pulse_enable_s;
  logic       tled_s;

  // optical pins into the system clock
  itc_sync #(.W(2), .RST_VAL(1'b0)) u_pin_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   ({tx_write_data_line, pd_rx_in}),
    .q   (pin_s)
  );

  // settings and LED block from the serial domain, all static levels
  itc_sync #(.W(13), .RST_VAL(1'b0)) u_cfg_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   ({l_q.led_block, l_q.cfg.ctrl0[C0_PM], l_q.cfg.ctrl0[C0_OEN],
           l_q.cfg.ctrl0[C0_TLED], l_q.cfg.ctrl0[C0_ACK_PULSE_ENABLE],
           l_q.cfg.ctrl1[3:0], l_q.cfg.ctrl2[7:4]}),
    .q   (cross_s)
  );

  assign {tx_s, pd_s} = pin_s;
  assign blk_s  = cross_s[12];
  assign oen_s  = cross_s[10];
  assign tled_s = cross_s[9];
  assign ack_pulse_enable_s = cross_s[8];

  // LED follows the write line while the bus is idle; photodiode path
  always_comb begin
    s_d         = s_q;
    s_d.led     = tx_s & ~blk_s & tled_s;
    s_d.pd_o    = ack_pulse_enable_s | pd_s;
    s_d.pd_oe   = oen_s;
    s_d.pm      = cross_s[11];
    s_d.ir_mode = cross_s[7:4];
    s_d.tx_pwr  = cross_s[3:0];
  end

  // system-domain state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // read line: serial owner when selected, else the photodiode path
  assign rx_read_data_line_o  = l_q.rx_sel ? l_q.drv    : s_q.pd_o;
  assign rx_read_data_line_oe = l_q.rx_sel ? l_q.drv_oe : s_q.pd_oe;
  assign led_drive      = s_q.led;
  assign power_mode     = s_q.pm;
  assign ir_mode        = s_q.ir_mode;
  assign tx_power_level = s_q.tx_pwr;

  // ------------------------------------------------------------- checks

  property p_slave_only;
    @(posedge link_clk) disable iff (link_rst)
    l_q.state inside {ITC_INIT, ITC_IDLE, ITC_CMD, ITC_WSTART, ITC_WDATA} |-> !l_q.drv_oe;
  endproperty
  a_slave_only: assert property (p_slave_only) else $error("slave drove line unasked");

  property p_turnaround;
    @(posedge link_clk) disable iff (link_rst)
    $rose(l_q.state == ITC_TURN) ##0 tx_line [*4] |=> l_q.state == ITC_RESP && !l_q.drv;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("response not 4 clocks late");

  property p_led_blocked;
    @(posedge link_clk) disable iff (link_rst)
    l_q.state inside {ITC_CMD, ITC_WSTART, ITC_WDATA, ITC_TURN, ITC_RESP} |-> l_q.led_block;
  endproperty
  a_led_blocked: assert property (p_led_blocked) else $error("LED open in command");

  property p_led_back;
    @(posedge link_clk) disable iff (link_rst)
    l_q.state == ITC_WDATA && l_q.cnt == BYTE_LAST |=> !l_q.led_block && l_q.state != ITC_WDATA;
  endproperty
  a_led_back: assert property (p_led_back) else $error("LED not released at end");

  property p_ack_pulse;
    @(posedge link_clk) disable iff (link_rst)
    $rose(l_q.state == ITC_ACK) |-> l_q.drv_oe && !l_q.drv ##1 !l_q.drv_oe && !l_q.rx_sel;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack pulse not one clock");

  property p_ack_cond;
    @(posedge link_clk) disable iff (link_rst)
    $rose(l_q.state == ITC_ACK) |->
      l_q.indiv && $past(l_q.cfg.ctrl0[C0_ACK_PULSE_ENABLE]) && $past(l_q.cfg.ctrl0[C0_OEN]);
  endproperty
  a_ack_cond: assert property (p_ack_cond) else $error("ack without its enables");

  property p_unaddressed;
    @(posedge link_clk) disable iff (link_rst)
    l_q.state inside {ITC_TURN, ITC_RESP} && !l_q.hit |-> !l_q.drv_oe && !l_q.rx_sel;
  endproperty
  a_unaddressed: assert property (p_unaddressed) else $error("unaddressed slave drove");

  property p_cfg_hold;
    @(posedge link_clk) disable iff (link_rst)
    l_q.state inside {ITC_IDLE, ITC_WSTART, ITC_ACK, ITC_TURN, ITC_RESP} |=> $stable(l_q.cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved mid command");

  property p_read_end;
    @(posedge link_clk) disable iff (link_rst)
    l_q.state == ITC_RESP && !tx_line |=>
      l_q.state == ITC_IDLE && !l_q.rx_sel && !l_q.drv_oe && !l_q.led_block;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read not ended on line fall");

  property p_lsb_first;
    @(posedge link_clk) disable iff (link_rst)
    l_q.state == ITC_RESP && tx_line && l_q.cnt < BYTE_DONE |=> l_q.drv == $past(l_q.shreg[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("response bit order wrong");

  property p_led_path;
    @(posedge clk) disable iff (sys_rst)
    s_q.led |-> $past(tx_s) && !$past(blk_s);
  endproperty
  a_led_path: assert property (p_led_path) else $error("LED lit without write line");

endmodule : itc_serial_ctrl

/* File: verification/itc_master_model.sv */
// itc_master_model: serial bus master that clocks commands into the slave
// and samples responses; assumes the read line is resolved with a pull-up.
`timescale 1ns/1ps

module itc_master_model (
  output logic      link_clk,
  output logic      tx_write_data_line,
  input  wire logic rx_line
);
  logic smp;

  // clock stands still between frames
  initial begin
    link_clk           = 1'b0;
    tx_write_data_line = 1'b0;
    smp                = 1'b1;
  end

  // one clock: data set after the fall, read line sampled before the rise
  task automatic tick(input logic v);
    tx_write_data_line = v;
    #16;
    smp      = rx_line;
    link_clk = 1'b1;
    #16;
    link_clk = 1'b0;
  endtask : tick

  // plain optical level on the write line while idle
  task automatic set_tx(input logic v);
    tx_write_data_line = v;
  endtask : set_tx

  // clocks with the write line held low
  task automatic init(input int n);
    repeat (n) tick(1'b0);
  endtask : init

  // start bit then byte lsb first, no gap clocks
  task automatic send_byte(input logic [7:0] b);
    tick(1'b1);
    for (int i = 0; i < 8; i++) tick(b[i]);
  endtask : send_byte

  // write: address, index, read flag clear; ack seen on the closing clock
  task automatic write(input logic [2:0] a, input logic [3:0] ix, input logic [7:0] d,
                       input logic with_data, output logic ack);
    send_byte({1'b0, ix, a});
    if (with_data) send_byte(d);
    tick(1'b0);
    ack = smp;
  endtask : write

  // read: line held high through the response, dropped two clocks to end
  task automatic read(input logic [2:0] a, input logic [3:0] ix,
                      output logic [7:0] d, output logic st);
    send_byte({1'b1, ix, a});
    for (int k = 9; k <= 21; k++) begin
      tick(1'b1);
      if (k == 13) st = smp;
      if (k > 13) d[k-14] = smp;
    end
    tick(1'b0);
    tick(1'b0);
  endtask : read
endmodule : itc_master_model

/* File: verification/tb.sv */
// tb: self-checking bench for itc_serial_ctrl with a register model in the bench.
// assumes the read line is pulled up whenever nobody drives it.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module tb;
  import itc_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic       pd_rx_in;
  logic       link_clk;
  logic       tx_line;
  logic       rx_o;
  logic       rx_oe;
  wire        rx_line;
  logic       led;
  logic       pm;
  logic [3:0] irm;
  logic [3:0] txp;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] c2;
  int         failures;
  int         num_checks;
  int         seed;

  // system clock, 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // read line with pull-up when released
  assign rx_line = rx_oe ? rx_o : 1'b1;

  itc_serial_ctrl dut (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .tx_write_data_line(tx_line),
    .pd_rx_in(pd_rx_in), .rx_read_data_line_o(rx_o), .rx_read_data_line_oe(rx_oe),
    .led_drive(led), .power_mode(pm), .ir_mode(irm), .tx_power_level(txp)
  );

  itc_master_model m (.link_clk(link_clk), .tx_write_data_line(tx_line), .rx_line(rx_line));

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // reset needs serial clocks too, so the master clocks low meanwhile
  task automatic do_reset;
    @(negedge clk);
    sys_rst = 1'b1;
    m.init(4);
    @(negedge clk);
    sys_rst = 1'b0;
    {c0, c1, c2} = CFG_RST;
  endtask : do_reset

  // mirrors, led pass-through and idle read line
  task automatic idle_check;
    logic p;
    p = 1'($random(seed));
    @(negedge clk);
    pd_rx_in = p;
    m.set_tx(1'b1);
    repeat (8) @(negedge clk);
    `CHK("power_mode", c0[C0_PM], pm)
    `CHK("ir_mode", c1[3:0], irm)
    `CHK("tx_power", c2[7:4], txp)
    `CHK("led_on", c0[C0_TLED], led)
    `CHK("rx_idle", c0[C0_OEN] ? (c0[C0_ACK_PULSE_ENABLE] | p) : 1'b1, rx_line)
    @(negedge clk);
    pd_rx_in = 1'b1;
    m.set_tx(1'b0);
    repeat (8) @(negedge clk);
    `CHK("led_off", 1'b0, led)
    `CHK("rx_oe", c0[C0_OEN], rx_oe)
  endtask : idle_check

  task automatic do_write(input logic [2:0] a, input logic [3:0] ix, input logic [7:0] d);
    logic hit;
    logic okv;
    logic ea;
    logic ack;
    hit = (a == ADDR_INDIV) || (a == ADDR_BCAST);
    okv = (ix != IDX_CTRL1) || (d inside {8'h01, 8'h02, 8'h04, 8'h08});
    ea  = hit && (a == ADDR_INDIV) && c0[C0_ACK_PULSE_ENABLE] && c0[C0_OEN] && okv
          && (ix <= IDX_CTRL2 || ix == IDX_RESET);
    m.write(a, ix, d, ix != IDX_RESET, ack);
    `CHK("ack", !ea, ack)
    if (hit) begin
      case (ix)
        IDX_CTRL0: c0 = d & CTRL0_MASK;
        IDX_CTRL1: c1 = okv ? d : 8'h00;
        IDX_CTRL2: c2 = d & CTRL2_MASK;
        IDX_RESET: {c0, c1, c2} = CFG_RST;
        default: ;
      endcase
    end
  endtask : do_write

  task automatic do_read(input logic [2:0] a, input logic [3:0] ix);
    logic       hit;
    logic       st;
    logic [7:0] d;
    logic [7:0] e;
    hit = (a == ADDR_INDIV) || (a == ADDR_BCAST);
    e   = !hit ? 8'hFF : ix == IDX_CTRL0 ? c0 : ix == IDX_CTRL1 ? c1 :
          ix == IDX_CTRL2 ? c2 : 8'h00;
    m.read(a, ix, d, st);
    `CHK("start_bit", !hit, st)
    `CHK("read_data", e, d)
  endtask : do_read

  // hang guard
  initial begin
    #2_000_000;
    failures++;
    $display("mismatch run_time expected %0d seen %0d", 0, 1);
    complete_run();
  end

  // main sequence
  initial begin
    logic [31:0] r;
    logic [2:0]  a;
    logic [3:0]  ix;
    logic        ack;
    int          n;
    seed       = 16842;
    failures   = 0;
    num_checks = 0;
    sys_rst    = 1'b1;
    pd_rx_in   = 1'b1;
    do_reset();
    // two extra edges: the serial side leaves reset through its own synchroniser
    m.init(INIT_EDGES + 2);
    idle_check();
    // every index code, oe still clear
    for (int i = 0; i < 16; i++) do_read(ADDR_INDIV, 4'(i));
    do_read(3'h2, IDX_CTRL0);
    do_write(ADDR_INDIV, IDX_CTRL0, 8'hFF);
    do_write(ADDR_INDIV, IDX_CTRL1, 8'h04);
    do_write(ADDR_INDIV, IDX_CTRL1, 8'h03);
    do_write(ADDR_BCAST, IDX_CTRL2, 8'hA5);
    do_write(3'h5, IDX_CTRL0, 8'h00);
    do_write(ADDR_INDIV, 4'h9, 8'h00);
    idle_check();
    // led must stay off while a frame with high data bits shifts in
    m.set_tx(1'b1);
    repeat (8) @(negedge clk);
    fork
      do_write(ADDR_INDIV, IDX_CTRL2, 8'hFF);
      begin
        #(32*15);
        `CHK("led_blocked", 1'b0, led)
      end
    join
    idle_check();
    do_write(ADDR_INDIV, IDX_RESET, 8'h00);
    idle_check();
    // random traffic over addresses, indices and data
    for (int i = 0; i < 28; i++) begin
      r  = $random(seed);
      a  = (r[1:0] == 2'b00) ? r[4:2] : r[0] ? ADDR_INDIV : ADDR_BCAST;
      ix = r[7] ? r[11:8] : {2'b00, r[9:8]};
      if (r[5]) begin
        do_read(a, ix);
      end else begin
        do_write(a, ix, r[6] ? (8'h01 << r[13:12]) : r[23:16]);
      end
      if (r[14]) idle_check();
    end
    // a high level during start-up restarts the low count
    do_reset();
    n = 1 + ($unsigned($random(seed)) % 28);
    m.init(n);
    m.tick(1'b1);
    m.init(29 - n);
    m.write(ADDR_INDIV, IDX_CTRL1, 8'h08, r[0], ack);
    m.init(INIT_EDGES + 2);
    do_read(ADDR_INDIV, IDX_CTRL1);
    idle_check();
    complete_run();
  end
endmodule : tb
